// ### common/fss_pkg.sv
package fss_pkg;
	localparam logic [5:0]  ADDR_POL      = 6'h0b;
	localparam logic [5:0]  ADDR_COMMON   = 6'h20;
	localparam logic [5:0]  ADDR_MOT_A    = 6'h22;
	localparam logic [5:0]  ADDR_MOT_B    = 6'h27;
	localparam logic [5:0]  OFF_WAIT      = 6'h00;
	localparam logic [5:0]  OFF_PEAK      = 6'h01;
	localparam logic [5:0]  OFF_CTRL      = 6'h02;
	localparam logic [5:0]  OFF_PERIOD    = 6'h03;
	localparam int          POL_BIT       = 9;
	localparam logic [7:0]  DT1_RST       = 8'h0a;
	localparam logic [7:0]  DT2_RST       = 8'h03;
	localparam logic [4:0]  PWM_DIV_RST   = 5'h1c;
	localparam logic [1:0]  PWM_RES_RST   = 2'h1;
	localparam int          WAIT_UNIT_CYC = 8192;
	localparam logic [4:0]  STEP_UNIT_CYC = 5'h18;
	localparam logic [8:0]  QUARTER_TURN  = 9'h080;
	localparam logic [7:0]  PEAK_MAG      = 8'h80;
	localparam logic [3:0]  ADV_MAX       = 4'h8;

	typedef struct packed {
		logic [5:0]  phase;
		logic [7:0]  dt2;
		logic [7:0]  peakB;
		logic [7:0]  peakA;
		logic [1:0]  micro;
		logic        led;
		logic        en;
		logic        brake;
		logic        dir;
		logic [7:0]  psum;
		logic [15:0] period;
	} fss_motor_t;

	typedef struct packed {
		logic [7:0]  dt2Cnt;
		logic        dt2Run;
		logic [10:0] left;
		logic [19:0] tmr;
		logic [7:0]  pos;
		logic        run;
	} fss_mstate_t;

	typedef struct packed {
		logic pwm;
		logic neg;
	} fss_coil_t;

	typedef struct packed {
		logic                syncPrev;
		logic                pol;
		logic [1:0]          pwm_resolution_select;
		logic [4:0]          pwmDiv;
		logic [7:0]          dt1;
		fss_motor_t [1:0]    wrMot;
		logic [1:0]          wPwmRes;
		logic [4:0]          wPwmDiv;
		fss_motor_t [1:0]    wkMot;
		fss_mstate_t [1:0]   ms;
		logic [15:0]         pre;
		logic [7:0]          dt1Cnt;
		logic                dt1Run;
		logic [10:0]         pwmCnt;
		fss_coil_t [3:0]     coil;
		logic [1:0]          hiZ;
		logic [1:0]          brk;
		logic [1:0]          led;
		logic [1:0]          busy;
	} fss_state_t;
endpackage

// ### rtl/fss_sequencer.sv
// Contract
// RL1: settings load into the working set once per frame, not at write time
// RL2: last loaded settings keep being used on every later frame
// RL3: start-point wait starts at active frame edge; motors move only after it
// RL4: start-point wait lasts wait value times 8192 clocks; resets to 0Ah
// RL5: zero start-point wait means no frame update is performed
// RL6: each motor has its own excitation wait after the common wait; resets 03h
// RL7: zero excitation wait means that motor's settings are not updated
// RL8: programmed steps run per frame; steps past the frame end are dropped
// RL9: zero step count stops the motor for that frame
// RL10: step period times 768 clocks is one electrical rotation
// RL11: each counted step takes 24 clocks times the step period
// RL12: microstep resolutions 64, 128 and 256 per motor
// RL13: resolution changes only waveform fineness, not amount or speed
// RL14: coil phase offset from 90 degrees by signed correction, -22.5..+21.8
// RL15: host updates phase correction when direction or period changes
// RL16: each driver amplitude set from its own 8-bit peak width
// RL17: host programs pwm, peaks and waits before first start wait ends
// RL18: brake forces coil current to zero at once
// RL19: cleared enable puts motor outputs high impedance; host avoids mid-run
// RL20: indicator bits apply on chip select falling edge
// RL21: second motor mirrors first; registers 27h-2Ah mirror 22h-25h
// RL22: polarity bit 0 selects rising frame edge, 1 selects falling
// RL23: data written after the refresh point applies at the next frame
// RL24: step count n gives 2n, 4n or 8n microsteps for 64, 128, 256
// RL25: after the steps, position and drive hold until next excitation wait ends; code loads new drive settings when the start-point wait ends
`timescale 1ns/10ps
module fss_sequencer #(
	parameter int WAIT_UNIT = fss_pkg::WAIT_UNIT_CYC
) (
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire logic                     frameSyncInput,
	input  wire logic                     regWrStb,
	input  wire logic [5:0]               regAddr,
	input  wire logic [15:0]              regData,
	input  wire logic                     csFall,
	output      fss_pkg::fss_coil_t [3:0] coilOut,
	output      logic [1:0]               motorHiZ,
	output      logic [1:0]               motorBrake,
	output      logic [1:0]               ledOut,
	output      logic [1:0]               motorBusy
);
	localparam logic [15:0] WAIT_LAST = 16'(WAIT_UNIT - 1);

	fss_pkg::fss_state_t st_r;
	fss_pkg::fss_state_t st_nxt;
	logic                activeEdge;
	logic                tick;
	logic                dt1End;
	logic [1:0]          dt2End;
	logic [5:0]          mBase [1:0];
	logic [5:0]          off   [1:0];
	logic [19:0]         stepLen [1:0];
	logic [7:0]          adv   [1:0];
	logic [8:0]          ph    [3:0];
	logic [7:0]          mag   [3:0];
	logic [7:0]          peak  [3:0];
	logic [15:0]         prod  [3:0];
	logic [10:0]         duty  [3:0];
	logic [4:0]          divEff;
	logic [10:0]         pwmPer;

	function automatic logic [1:0] stepShift(input logic [1:0] micro);
		case (micro)
			2'h2:    stepShift = 2'h2;
			2'h3:    stepShift = 2'h1;
			default: stepShift = 2'h3;
		endcase
	endfunction

	always_comb begin
		st_nxt = st_r;
		st_nxt.syncPrev = frameSyncInput;
		activeEdge = st_r.pol ? (st_r.syncPrev & ~frameSyncInput) //RL22
			: (~st_r.syncPrev & frameSyncInput);
		tick = (st_r.pre == WAIT_LAST);
		st_nxt.pre = tick ? 16'h0000 : st_r.pre + 16'h0001;
		mBase[0] = fss_pkg::ADDR_MOT_A;
		mBase[1] = fss_pkg::ADDR_MOT_B; //RL21
		// register writes land in the written set only
		if (regWrStb) begin
			if (regAddr == fss_pkg::ADDR_POL) begin
				st_nxt.pol = regData[fss_pkg::POL_BIT];
			end
			if (regAddr == fss_pkg::ADDR_COMMON) begin
				st_nxt.pwm_resolution_select = regData[14:13];
				st_nxt.pwmDiv = regData[12:8];
				st_nxt.dt1 = regData[7:0];
			end
		end
		for (int m = 0; m < 2; m++) begin
			off[m] = regAddr - mBase[m];
			if (regWrStb) begin
				case (off[m])
					fss_pkg::OFF_WAIT: begin
						st_nxt.wrMot[m].phase = regData[13:8];
						st_nxt.wrMot[m].dt2 = regData[7:0];
					end
					fss_pkg::OFF_PEAK: begin
						st_nxt.wrMot[m].peakB = regData[15:8];
						st_nxt.wrMot[m].peakA = regData[7:0];
					end
					fss_pkg::OFF_CTRL: begin
						st_nxt.wrMot[m].micro = regData[13:12];
						st_nxt.wrMot[m].led = regData[11];
						st_nxt.wrMot[m].en = regData[10];
						st_nxt.wrMot[m].brake = regData[9];
						st_nxt.wrMot[m].dir = regData[8];
						st_nxt.wrMot[m].psum = regData[7:0];
					end
					fss_pkg::OFF_PERIOD: begin
						st_nxt.wrMot[m].period = regData;
					end
					default: begin
					end
				endcase
			end
			if (csFall) begin
				st_nxt.led[m] = st_nxt.wrMot[m].led; //RL20
			end
		end
		// common start-point wait
		dt1End = st_r.dt1Run & tick & (st_r.dt1Cnt == 8'h01); //RL4
		if (st_r.dt1Run & tick) begin
			st_nxt.dt1Cnt = st_r.dt1Cnt - 8'h01;
		end
		if (dt1End) begin
			st_nxt.dt1Run = 1'b0;
		end
		for (int m = 0; m < 2; m++) begin
			dt2End[m] = st_r.ms[m].dt2Run & tick & (st_r.ms[m].dt2Cnt == 8'h01);
			stepLen[m] = 20'(20'(st_r.wkMot[m].period) //RL10 RL11
				* 20'(fss_pkg::STEP_UNIT_CYC >> stepShift(st_r.wkMot[m].micro)));
			adv[m] = 8'(fss_pkg::ADV_MAX >> stepShift(st_r.wkMot[m].micro)); //RL12 RL13
			if (dt1End && st_r.wrMot[m].dt2 != 8'h00) begin
				st_nxt.wkMot[m] = st_r.wrMot[m]; //RL7 RL23
				st_nxt.ms[m].dt2Cnt = st_r.wrMot[m].dt2; //RL6
				st_nxt.ms[m].dt2Run = 1'b1;
			end
			if (st_r.ms[m].dt2Run & tick) begin
				st_nxt.ms[m].dt2Cnt = st_r.ms[m].dt2Cnt - 8'h01;
			end
			if (dt2End[m]) begin
				st_nxt.ms[m].dt2Run = 1'b0;
				st_nxt.ms[m].left = {3'h0, st_r.wkMot[m].psum} //RL24
					<< stepShift(st_r.wkMot[m].micro);
				st_nxt.ms[m].run = (st_r.wkMot[m].psum != 8'h00); //RL9
				st_nxt.ms[m].tmr = 20'h00000;
			end
			if (st_r.ms[m].run) begin
				if ((st_r.ms[m].tmr + 20'h00001) >= stepLen[m]) begin
					st_nxt.ms[m].tmr = 20'h00000;
					st_nxt.ms[m].pos = st_r.wkMot[m].dir ? st_r.ms[m].pos - adv[m]
						: st_r.ms[m].pos + adv[m];
					st_nxt.ms[m].left = st_r.ms[m].left - 11'h001;
					st_nxt.ms[m].run = (st_r.ms[m].left != 11'h001); //RL25
				end else begin
					st_nxt.ms[m].tmr = st_r.ms[m].tmr + 20'h00001;
				end
			end
		end
		// frame edge restarts timing and drops unfinished steps
		if (activeEdge) begin
			st_nxt.pre = 16'h0000; //RL3
			st_nxt.dt1Cnt = st_r.dt1;
			st_nxt.dt1Run = (st_r.dt1 != 8'h00); //RL5
			if (st_r.dt1 != 8'h00) begin
				st_nxt.wPwmRes = st_r.pwm_resolution_select; //RL1 RL2
				st_nxt.wPwmDiv = st_r.pwmDiv;
			end
			for (int m = 0; m < 2; m++) begin
				st_nxt.ms[m].run = 1'b0; //RL8
				st_nxt.ms[m].left = 11'h000;
				st_nxt.ms[m].dt2Run = 1'b0;
			end
		end
		// pwm carrier and coil drive
		divEff = (st_r.wPwmDiv == 5'h00) ? 5'h01 : st_r.wPwmDiv;
		pwmPer = ({6'h00, divEff} << 3) << st_r.wPwmRes;
		st_nxt.pwmCnt = (st_r.pwmCnt >= pwmPer - 11'h001) ? 11'h000
			: st_r.pwmCnt + 11'h001;
		for (int d = 0; d < 4; d++) begin
			ph[d] = {st_r.ms[d / 2].pos, 1'b0};
			peak[d] = st_r.wkMot[d / 2].peakA;
			if (d % 2 == 1) begin
				ph[d] = ph[d] + fss_pkg::QUARTER_TURN //RL14
					+ {{3{st_r.wkMot[d / 2].phase[5]}}, st_r.wkMot[d / 2].phase};
				peak[d] = st_r.wkMot[d / 2].peakB;
			end
			mag[d] = ph[d][7] ? fss_pkg::PEAK_MAG - {1'b0, ph[d][6:0]}
				: {1'b0, ph[d][6:0]};
			prod[d] = {8'h00, peak[d]} * {8'h00, mag[d]}; //RL16
			duty[d] = {3'h0, prod[d][14:7]} << st_r.wPwmRes;
			st_nxt.coil[d].pwm = st_r.wkMot[d / 2].en & ~st_r.wkMot[d / 2].brake //RL18
				& (st_r.pwmCnt < duty[d]);
			st_nxt.coil[d].neg = ph[d][8];
		end
		for (int m = 0; m < 2; m++) begin
			st_nxt.hiZ[m] = ~st_r.wkMot[m].en; //RL19
			st_nxt.brk[m] = st_r.wkMot[m].brake;
			st_nxt.busy[m] = st_r.ms[m].run | st_r.ms[m].dt2Run;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.dt1 <= fss_pkg::DT1_RST; //RL4
			st_r.pwmDiv <= fss_pkg::PWM_DIV_RST;
			st_r.pwm_resolution_select <= fss_pkg::PWM_RES_RST;
			st_r.wPwmDiv <= fss_pkg::PWM_DIV_RST;
			st_r.wPwmRes <= fss_pkg::PWM_RES_RST;
			st_r.wrMot[0].dt2 <= fss_pkg::DT2_RST; //RL6
			st_r.wrMot[1].dt2 <= fss_pkg::DT2_RST;
			st_r.hiZ <= 2'h3;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign coilOut = st_r.coil;
	assign motorHiZ = st_r.hiZ;
	assign motorBrake = st_r.brk;
	assign ledOut = st_r.led;
	assign motorBusy = st_r.busy;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	AST_FRAME_LOAD: assert property (activeEdge && st_r.dt1 != 8'h00 |=> //RL1
		st_r.dt1Run && st_r.dt1Cnt == $past(st_r.dt1)
		&& st_r.wPwmDiv == $past(st_r.pwmDiv))
		else $error("frame edge did not load the start wait");
	AST_ZERO_WAIT: assert property (activeEdge && st_r.dt1 == 8'h00 |=> //RL5
		!st_r.dt1Run)
		else $error("zero start wait still ran");
	AST_WAIT_END: assert property ($fell(st_r.dt1Run) |-> //RL4
		$past(tick) && $past(st_r.dt1Cnt) == 8'h01)
		else $error("start wait ended off count");
	AST_NO_EARLY: assert property (st_r.ms[0].run || st_r.ms[1].run |-> //RL3
		!st_r.dt1Run)
		else $error("motor ran during start wait");
	AST_DT2_START: assert property (dt1End && !activeEdge //RL6
		&& st_r.wrMot[0].dt2 != 8'h00 |=> st_r.ms[0].dt2Run
		&& st_r.ms[0].dt2Cnt == $past(st_r.wrMot[0].dt2))
		else $error("excitation wait not started");
	AST_DISCARD: assert property (activeEdge |=> !st_r.ms[0].run //RL8
		&& !st_r.ms[1].run && st_r.ms[0].left == 11'h000)
		else $error("steps survived frame edge");
	AST_ZERO_STEPS: assert property (dt2End[0] && !activeEdge //RL9
		&& st_r.wkMot[0].psum == 8'h00 |=> !st_r.ms[0].run)
		else $error("zero step count ran");
	AST_COUNT: assert property (dt2End[1] && !activeEdge |=> //RL24
		st_r.ms[1].left == ({3'h0, $past(st_r.wkMot[1].psum)}
		<< stepShift($past(st_r.wkMot[1].micro))))
		else $error("microstep count wrong");
	AST_BRAKE: assert property (st_r.wkMot[0].brake && $past(st_r.wkMot[0].brake) //RL18
		|-> !st_r.coil[0].pwm && !st_r.coil[1].pwm && st_r.brk[0])
		else $error("brake left current on");
	AST_HIZ: assert property (!st_r.wkMot[1].en && $past(!st_r.wkMot[1].en) //RL19
		|-> st_r.hiZ[1] && !st_r.coil[2].pwm && !st_r.coil[3].pwm)
		else $error("disabled motor driven");
	AST_LED: assert property (csFall && !regWrStb |=> //RL20
		st_r.led[1] == $past(st_r.wrMot[1].led))
		else $error("indicator not applied on cs fall");

	COV_RUN: cover property (dt2End[0] && st_r.wkMot[0].psum != 8'h00);
	COV_CUT: cover property (st_r.ms[1].run && activeEdge);
	COV_DONE: cover property ($fell(st_r.ms[0].run) && !st_r.dt1Run);
	COV_LED: cover property (csFall && regWrStb);
endmodule // fss_sequencer

// ### sim/fss_motor_model.sv
`timescale 1ns/10ps
module fss_motor_model (
	input  wire logic                     sys_clk,
	input  wire fss_pkg::fss_coil_t [3:0] coilOut,
	input  wire logic [1:0]               motorHiZ,
	input  wire logic                     clr,
	output      logic [3:0]               drove
);
	// a coil carries current only while its motor is driven and pwm is high
	always @(posedge sys_clk) begin
		if (clr) begin
			drove <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (coilOut[i].pwm === 1'b1 && motorHiZ[i/2] === 1'b0) begin
					drove[i] <= 1'b1;
				end
			end
		end
	end
endmodule // fss_motor_model

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
	localparam int WU = 4;
	localparam int F  = 150;
	typedef struct {int st; int du;} fss_note_t;
	logic                     sys_clk = 1'b0;
	logic                     reset_n = 1'b0;
	logic                     frameSyncInput = 1'b0;
	logic                     regWrStb = 1'b0;
	logic [5:0]               regAddr = 6'h00;
	logic [15:0]              regData = 16'h0000;
	logic                     csFall = 1'b0;
	logic                     clr = 1'b1;
	logic                     pol = 1'b0;
	fss_pkg::fss_coil_t [3:0] coilOut;
	logic [1:0]               motorHiZ, motorBrake, ledOut, motorBusy;
	logic [1:0]               bz = 2'h0;
	logic [3:0]               drove;
	fss_note_t                q[2][$];
	fss_note_t                e;
	int                       n_errors = 0, checked = 0, cyc = 0, fc = 0;
	int                       seed = 32'h8fcb, n, d1, d2, rs[2], t0[2];

	always #50 sys_clk = ~sys_clk;

	fss_sequencer #(.WAIT_UNIT(WU)) i_fss_sequencer (
		.sys_clk        (sys_clk),
		.reset_n        (reset_n),
		.frameSyncInput (frameSyncInput),
		.regWrStb       (regWrStb),
		.regAddr        (regAddr),
		.regData        (regData),
		.csFall         (csFall),
		.coilOut        (coilOut),
		.motorHiZ       (motorHiZ),
		.motorBrake     (motorBrake),
		.ledOut         (ledOut),
		.motorBusy      (motorBusy)
	);

	fss_motor_model i_fss_motor_model (
		.sys_clk  (sys_clk),
		.coilOut  (coilOut),
		.motorHiZ (motorHiZ),
		.clr      (clr),
		.drove    (drove)
	);

	task final_report();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task chkv(input string s, input logic [1:0] x, input logic [1:0] g);
		checked++;
		if (g !== x) begin
			n_errors++;
			$display("MISMATCH %s exp %b got %b", s, x, g);
		end
	endtask

	task chkn(input string s, input int x, input int g, input int tol);
		checked++;
		if (g < x - tol || g > x + tol) begin
			n_errors++;
			$display("MISMATCH %s exp %0d got %0d", s, x, g);
		end
	endtask

	function int dur(input int w, input int s);
		return w * WU + 24 * s;
	endfunction

	task wr(input logic [5:0] a, input logic [15:0] d, input logic cs = 1'b0);
		@(negedge sys_clk);
		regWrStb = 1'b1;
		regAddr = a;
		regData = d;
		csFall = cs;
		@(negedge sys_clk);
		regWrStb = 1'b0;
		csFall = 1'b0;
	endtask

	task com(input logic [7:0] w);
		d1 = w;
		wr(fss_pkg::ADDR_COMMON, {3'b001, 5'h1c, w});
	endtask

	task mot(input int m, input logic [7:0] w, input logic [7:0] ps, input logic [1:0] mi,
		input logic [2:0] ctl, input logic [15:0] pk);
		logic [5:0] b;
		b = m ? fss_pkg::ADDR_MOT_B : fss_pkg::ADDR_MOT_A;
		wr(b, {2'b00, 6'($random(seed)), w});
		wr(b + fss_pkg::OFF_PEAK, pk);
		wr(b + fss_pkg::OFF_CTRL, {2'b00, mi, 1'b0, ctl, ps});
		wr(b + fss_pkg::OFF_PERIOD, 16'h0001);
	endtask

	// a negative length means the run must end at the next frame edge
	task frame(input int e0, input int e1);
		if (e0 != 0) q[0].push_back('{d1 * WU + 1, e0});
		if (e1 != 0) q[1].push_back('{d1 * WU + 1, e1});
		@(negedge sys_clk);
		frameSyncInput = ~pol;
		fc = cyc + 1;
		repeat (20) @(negedge sys_clk);
		frameSyncInput = pol;
		repeat (F - 20) @(negedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cyc++;
	end

	// busy is sampled on the falling edge, where it has settled
	always @(negedge sys_clk) begin
		for (int m = 0; m < 2; m++) begin
			if (motorBusy[m] === 1'b1 && bz[m] === 1'b0) begin
				rs[m] = cyc - fc;
				t0[m] = cyc;
			end
			if (motorBusy[m] === 1'b0 && bz[m] === 1'b1) begin
				if (q[m].size() == 0) begin
					chkn("stray busy", 0, 1, 0);
				end else begin
					e = q[m].pop_front();
					chkn("start", e.st, rs[m], 0);
					chkn("length", e.du < 0 ? fc - t0[m] + 1 : e.du, cyc - t0[m], 0);
				end
			end
			bz[m] = motorBusy[m];
		end
	end

	initial begin
		#3000000;
		n_errors++;
		final_report();
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		reset_n = 1'b1;
		clr = 1'b0;
		chkv("hiz", 2'b11, motorHiZ);
		chkv("busy", 2'b00, motorBusy);
		wr(fss_pkg::ADDR_MOT_A + fss_pkg::OFF_CTRL, 16'h0800, 1'b1);
		chkv("led", 2'b01, ledOut);
		wr(fss_pkg::ADDR_MOT_B + fss_pkg::OFF_CTRL, 16'h0800);
		chkv("led", 2'b01, ledOut);
		wr(fss_pkg::ADDR_POL, 16'h0000, 1'b1);
		chkv("led", 2'b11, ledOut);
		com(8'h02);
		for (int k = 0; k < 4; k++) begin
			n = 1 + $unsigned($random(seed)) % 3;
			d2 = 1 + $unsigned($random(seed)) % 3;
			mot(0, d2[7:0], n[7:0], k[1:0], 3'b100, 16'hffff);
			mot(1, 8'(d2 + 1), n[7:0], k[1:0], 3'b100, 16'hffff);
			chkv("hiz", k ? 2'b00 : 2'b11, motorHiZ);
			frame(dur(d2, n), dur(d2 + 1, n));
			chkv("hiz", 2'b00, motorHiZ);
		end
		frame(dur(d2, n), dur(d2 + 1, n));
		mot(0, 8'h02, 8'h00, 2'b00, 3'b100, 16'hffff);
		mot(1, 8'h00, 8'h03, 2'b00, 3'b100, 16'hffff);
		frame(dur(2, 0), 0);
		com(8'h00);
		frame(0, 0);
		wr(fss_pkg::ADDR_POL, 16'h0200);
		@(negedge sys_clk);
		frameSyncInput = 1'b1;
		pol = 1'b1;
		com(8'h03);
		frame(dur(2, 0), 0);
		mot(0, 8'h01, 8'h00, 2'b00, 3'b110, 16'hffff);
		mot(1, 8'h01, 8'h01, 2'b00, 3'b100, 16'hff00);
		frame(dur(1, 0), dur(1, 1));
		@(negedge sys_clk);
		clr = 1'b1;
		@(negedge sys_clk);
		clr = 1'b0;
		frame(dur(1, 0), dur(1, 1));
		chkv("brake", 2'b01, motorBrake);
		chkv("coil ab", 2'b00, drove[1:0]);
		chkv("coil c", 2'b00, {1'b0, drove[2]});
		mot(0, 8'h01, 8'hff, 2'b00, 3'b100, 16'hffff);
		frame(-1, dur(1, 1));
		mot(0, 8'h01, 8'h00, 2'b00, 3'b000, 16'hffff);
		frame(dur(1, 0), dur(1, 1));
		chkv("hiz", 2'b01, motorHiZ);
		chkn("notes left", 0, q[0].size() + q[1].size(), 0);
		final_report();
	end
endmodule // tb
